// ---- core/ldg_low_power_card_detect.sv ----
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ldg_low_power_card_detect (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  input  wire logic [ldg_pkg::AW-1:0]   reg_addr,
  input  wire logic [ldg_pkg::DW-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [ldg_pkg::DW-1:0]   reg_rdata,
  input  wire logic                     wake_tick,
  input  wire logic [ldg_pkg::AGC_W-1:0] agc_value,
  output logic                          rf_field_on,
  output logic                          supply_wake1,
  output logic                          supply_wake2,
  output logic                          irq
);
  ldg_delay_if dly ();
  ldg_event_if ev ();

  ldg_delay u_delay (
    .mclk   (mclk),
    .reset  (reset),
    .clk_en (clk_en),
    .dly    (dly.timer)
  );

  ldg_irq u_irq (
    .mclk   (mclk),
    .reset  (reset),
    .clk_en (clk_en),
    .ev     (ev.keeper),
    .irq    (irq)
  );

  function automatic logic hit_reg(
    input logic [ldg_pkg::AW-1:0] addr,
    input logic [5:0]             idx
  );
    return addr == {idx, 2'b00};
  endfunction

  logic [ldg_pkg::REF_W-1:0] stored_reference;
  logic [7:0]                field_on_duration;
  logic [7:0]                detect_threshold;
  logic [7:0]                reference_select_byte_new;
  logic [7:0]                output_lead_time;
  logic [7:0]                output_trail_time;
  logic [ldg_pkg::REF_W-1:0] gain_loop_config_register;
  logic [1:0]                ctrl;
  logic [ldg_pkg::EVT_W-1:0] irq_mask;
  logic [ldg_pkg::AGC_W-1:0] measured_ref;
  logic                      measured_ok;
  ldg_pkg::ldg_state_e       state;
  logic                      one_shot;
  logic                      first_supply_wake_output_on;
  logic                      last_hit;

  logic                      check_req;
  logic                      loop_start;
  logic                      fw_new;
  logic                      loop_en;
  logic [1:0]                src;
  logic                      first_supply_wake_output_want;
  logic                      cycle_go;
  logic                      lead_done;
  logic                      field_done;
  logic                      finish;
  logic [ldg_pkg::AGC_W-1:0] ref_now;
  logic                      ref_ok;
  logic [ldg_pkg::AGC_W-1:0] agc_diff;
  logic                      hit;

  always_comb
  begin
    check_req = clk_en && reg_wr && hit_reg(reg_addr, ldg_pkg::IDX_CHECK_CARD);
    // Only a ctrl write takes idle to standby, so a detect stays stopped
    loop_start = clk_en && reg_wr && hit_reg(reg_addr, ldg_pkg::IDX_CTRL) &&
      reg_wdata[ldg_pkg::CTRL_LOOP];
    fw_new    = ctrl[ldg_pkg::CTRL_NEW_FW];
    loop_en   = ctrl[ldg_pkg::CTRL_LOOP];
    src       = reference_select_byte_new[ldg_pkg::SEL_SRC_LSB +: 2];
  end

  // Bit 4 only covers wake-up from standby, not a check-card pass
  always_comb
  begin
    if (fw_new)
      first_supply_wake_output_want = reference_select_byte_new[ldg_pkg::SEL_FIRST_SUPPLY_WAKE_OUTPUT_RF] ||
        (reference_select_byte_new[ldg_pkg::SEL_FIRST_SUPPLY_WAKE_OUTPUT_WAKE] &&
         !check_req);
    else
      first_supply_wake_output_want = reference_select_byte_new[ldg_pkg::SEL_FIRST_SUPPLY_WAKE_OUTPUT_RF];
  end

  always_comb
  begin
    cycle_go = (state == ldg_pkg::ST_IDLE || state == ldg_pkg::ST_STANDBY) &&
      (check_req ||
       (clk_en && state == ldg_pkg::ST_STANDBY && loop_en && wake_tick));
    lead_done  = state == ldg_pkg::ST_LEAD && dly.done;
    field_done = state == ldg_pkg::ST_FIELD && dly.done;
    finish     = (state == ldg_pkg::ST_COMPARE && !first_supply_wake_output_on) ||
      (state == ldg_pkg::ST_TRAIL && dly.done);
  end

  always_comb
  begin
    case (src)
      ldg_pkg::SRC_STORED:
      begin
        ref_now = stored_reference[ldg_pkg::AGC_W-1:0];
        ref_ok  = 1'b1;
      end
      ldg_pkg::SRC_MEASURE:
      begin
        ref_now = measured_ref;
        ref_ok  = measured_ok;
      end
      ldg_pkg::SRC_GAIN_CFG:
      begin
        ref_now = gain_loop_config_register[ldg_pkg::AGC_W-1:0];
        ref_ok  = 1'b1;
      end
      default:
      begin
        ref_now = '0;
        ref_ok  = 1'b0;
      end
    endcase
    agc_diff = (ref_now > agc_value) ? ref_now - agc_value
                                     : agc_value - ref_now;
    hit = state == ldg_pkg::ST_COMPARE && ref_ok &&
      agc_diff > {2'b00, detect_threshold};
  end

  // Lead and trail are skipped when output one is not in use
  always_comb
  begin
    dly.start     = clk_en && ((cycle_go && first_supply_wake_output_want) ||
      (cycle_go && !first_supply_wake_output_want) || lead_done ||
      (state == ldg_pkg::ST_COMPARE && first_supply_wake_output_on));
    dly.long_unit = (cycle_go && !first_supply_wake_output_want) || lead_done;
    if (dly.long_unit)
      dly.count = field_on_duration;
    else if (cycle_go)
      dly.count = output_lead_time;
    else
      dly.count = output_trail_time;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      stored_reference          <= ldg_pkg::REF_RST;
      field_on_duration         <= ldg_pkg::BYTE_RST;
      detect_threshold          <= ldg_pkg::BYTE_RST;
      reference_select_byte_new <= ldg_pkg::BYTE_RST;
      output_lead_time          <= ldg_pkg::BYTE_RST;
      output_trail_time         <= ldg_pkg::BYTE_RST;
      gain_loop_config_register <= ldg_pkg::REF_RST;
      ctrl                      <= ldg_pkg::CTRL_RST;
      irq_mask                  <= ldg_pkg::MASK_RST;
    end
    else if (clk_en && reg_wr)
    begin
      if (hit_reg(reg_addr, ldg_pkg::IDX_REF_STORE))
        stored_reference <= reg_wdata[ldg_pkg::REF_W-1:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_FIELD_ON))
        field_on_duration <= reg_wdata[7:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_THRESH))
        detect_threshold <= reg_wdata[7:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_SELECT))
        reference_select_byte_new <= reg_wdata[7:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_LEAD))
        output_lead_time <= reg_wdata[7:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_TRAIL))
        output_trail_time <= reg_wdata[7:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_GAIN_CFG))
        gain_loop_config_register <= reg_wdata[ldg_pkg::REF_W-1:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_CTRL))
        ctrl <= reg_wdata[1:0];
      if (hit_reg(reg_addr, ldg_pkg::IDX_IRQ_MASK))
        irq_mask <= reg_wdata[ldg_pkg::EVT_W-1:0];
    end
  end

  // A new select byte forces a fresh measured reference
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      measured_ref <= '0;
      measured_ok  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_wr && hit_reg(reg_addr, ldg_pkg::IDX_SELECT))
        measured_ok <= 1'b0;
      else if (state == ldg_pkg::ST_COMPARE && src == ldg_pkg::SRC_MEASURE &&
               !measured_ok)
      begin
        measured_ref <= agc_value;
        measured_ok  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state    <= ldg_pkg::ST_IDLE;
      one_shot <= 1'b0;
      first_supply_wake_output_on  <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state)
        ldg_pkg::ST_IDLE,
        ldg_pkg::ST_STANDBY:
        begin
          if (cycle_go)
          begin
            one_shot <= check_req;
            first_supply_wake_output_on  <= first_supply_wake_output_want;
            state    <= first_supply_wake_output_want ? ldg_pkg::ST_LEAD : ldg_pkg::ST_FIELD;
          end
          else if (loop_start)
            state <= ldg_pkg::ST_STANDBY;
          else if (!loop_en)
            state <= ldg_pkg::ST_IDLE;
        end
        ldg_pkg::ST_LEAD:
          if (dly.done)
            state <= ldg_pkg::ST_FIELD;
        ldg_pkg::ST_FIELD:
          if (dly.done)
            state <= ldg_pkg::ST_COMPARE;
        ldg_pkg::ST_COMPARE:
          if (first_supply_wake_output_on)
            state <= ldg_pkg::ST_TRAIL;
        ldg_pkg::ST_TRAIL:
          ;
        default:
          state <= ldg_pkg::ST_IDLE;
      endcase
      // Detection or a one-shot pass ends the loop
      if (finish)
        state <= (loop_en && !one_shot && !last_hit && !hit) ?
          ldg_pkg::ST_STANDBY : ldg_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      last_hit <= 1'b0;
    else if (clk_en)
    begin
      if (cycle_go)
        last_hit <= 1'b0;
      else if (hit)
        last_hit <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rf_field_on <= 1'b0;
    else if (clk_en)
    begin
      if ((cycle_go && !first_supply_wake_output_want) || lead_done)
        rf_field_on <= 1'b1;
      else if (field_done)
        rf_field_on <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      supply_wake1 <= 1'b0;
    else if (clk_en)
    begin
      if (cycle_go && first_supply_wake_output_want)
        supply_wake1 <= 1'b1;
      else if (state == ldg_pkg::ST_TRAIL && dly.done)
        supply_wake1 <= 1'b0;
    end
  end

  // Held for the regulator until software reads the status or a new cycle starts
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      supply_wake2 <= 1'b0;
    else if (clk_en)
    begin
      if (hit && fw_new && reference_select_byte_new[ldg_pkg::SEL_SECOND_SUPPLY_WAKE_OUTPUT_DET])
        supply_wake2 <= 1'b1;
      else if (ev.stat_rd || cycle_go)
        supply_wake2 <= 1'b0;
    end
  end

  always_comb
  begin
    ev.evt                     = '0;
    ev.evt[ldg_pkg::EVT_DETECT] = clk_en && hit;
    ev.evt[ldg_pkg::EVT_DONE]   = clk_en && finish;
    ev.stat_rd = clk_en && reg_rd && hit_reg(reg_addr, ldg_pkg::IDX_IRQ_STAT);
    ev.mask    = irq_mask;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        if (hit_reg(reg_addr, ldg_pkg::IDX_CHECK_CARD))
        begin
          reg_rdata[ldg_pkg::CHK_BUSY] <= one_shot &&
            state != ldg_pkg::ST_IDLE && state != ldg_pkg::ST_STANDBY;
          reg_rdata[ldg_pkg::CHK_HIT] <= last_hit;
        end
        if (hit_reg(reg_addr, ldg_pkg::IDX_REF_STORE))
          reg_rdata[ldg_pkg::REF_W-1:0] <= stored_reference;
        if (hit_reg(reg_addr, ldg_pkg::IDX_FIELD_ON))
          reg_rdata[7:0] <= field_on_duration;
        if (hit_reg(reg_addr, ldg_pkg::IDX_THRESH))
          reg_rdata[7:0] <= detect_threshold;
        if (hit_reg(reg_addr, ldg_pkg::IDX_SELECT))
          reg_rdata[7:0] <= reference_select_byte_new;
        if (hit_reg(reg_addr, ldg_pkg::IDX_LEAD))
          reg_rdata[7:0] <= output_lead_time;
        if (hit_reg(reg_addr, ldg_pkg::IDX_TRAIL))
          reg_rdata[7:0] <= output_trail_time;
        if (hit_reg(reg_addr, ldg_pkg::IDX_GAIN_CFG))
          reg_rdata[ldg_pkg::REF_W-1:0] <= gain_loop_config_register;
        if (hit_reg(reg_addr, ldg_pkg::IDX_CTRL))
          reg_rdata[1:0] <= ctrl;
        if (hit_reg(reg_addr, ldg_pkg::IDX_IRQ_STAT))
          reg_rdata[ldg_pkg::EVT_W-1:0] <= ev.status;
        if (hit_reg(reg_addr, ldg_pkg::IDX_IRQ_MASK))
          reg_rdata[ldg_pkg::EVT_W-1:0] <= irq_mask;
      end
    end
  end

  // Cycles since the last timer start, for timing checks
  logic [ldg_pkg::DLY_W-1:0] phase_cyc;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      phase_cyc <= '0;
    else if (clk_en)
      phase_cyc <= dly.start ? '0 : phase_cyc + ldg_pkg::DLY_W'(1);
  end

  default clocking dc @(posedge mclk iff clk_en);
  endclocking
  default disable iff (reset);

  sequence s_go_with_first_supply_wake_output;
    cycle_go && first_supply_wake_output_want;
  endsequence
  sequence s_wake1_up;
    supply_wake1 && first_supply_wake_output_on;
  endsequence

  ref_gain_sel_a: assert property (
    hit && src == ldg_pkg::SRC_GAIN_CFG |->
      ref_now == gain_loop_config_register[ldg_pkg::AGC_W-1:0])
    else $error("reference not taken from gain config");
  old_first_supply_wake_output_off_a: assert property (
    cycle_go && !fw_new &&
      !reference_select_byte_new[ldg_pkg::SEL_FIRST_SUPPLY_WAKE_OUTPUT_RF] |=>
      (!first_supply_wake_output_on && !supply_wake1) [*2])
    else $error("output one driven while disabled");
  early_wake_a: assert property (
    s_go_with_first_supply_wake_output |=> s_wake1_up ##1 !rf_field_on)
    else $error("output one not raised ahead of field");
  wake2_cause_a: assert property (
    $rose(supply_wake2) |->
      $past(fw_new && reference_select_byte_new[ldg_pkg::SEL_SECOND_SUPPLY_WAKE_OUTPUT_DET] && hit))
    else $error("output two raised without enable and detect");
  wake_bit4_a: assert property (
    cycle_go && fw_new && !check_req &&
      reference_select_byte_new[ldg_pkg::SEL_FIRST_SUPPLY_WAKE_OUTPUT_WAKE] |=> supply_wake1)
    else $error("output one not raised on wake");
  lead_time_a: assert property (
    lead_done |-> phase_cyc ==
      ldg_pkg::delay_cycles(output_lead_time, 1'b0) + ldg_pkg::DLY_W'(1))
    else $error("lead delay length wrong");
  trail_time_a: assert property (
    $fell(supply_wake1) |-> $past(phase_cyc) ==
      ldg_pkg::delay_cycles(output_trail_time, 1'b0) + ldg_pkg::DLY_W'(1)
      && !rf_field_on)
    else $error("trail delay length wrong");
  one_pass_a: assert property (
    finish && one_shot |=> (state == ldg_pkg::ST_IDLE) [*2])
    else $error("check-card pass did not stop");
  detect_flag_a: assert property (
    hit |=> ev.status[ldg_pkg::EVT_DETECT] && state != ldg_pkg::ST_FIELD)
    else $error("detect event lost");
  field_time_a: assert property (
    field_done |-> rf_field_on && phase_cyc ==
      ldg_pkg::delay_cycles(field_on_duration, 1'b1) + ldg_pkg::DLY_W'(1))
    else $error("field-on duration wrong");
  idle_level_a: assert property (
    cycle_go && !first_supply_wake_output_want |=> !supply_wake1 throughout
      (state == ldg_pkg::ST_FIELD ##1 1'b1))
    else $error("disabled output left idle level");
endmodule
`default_nettype wire

// ---- shared/ldg_pkg.sv ----
`default_nettype none
package ldg_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LEAD_UNIT_NS  = 5000;
  localparam int FIELD_UNIT_NS = 8000;
  localparam int LEAD_UNIT_CYC =
    (LEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIELD_UNIT_CYC =
    (FIELD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 17;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int AGC_W = 10;
  localparam int REF_W = 14;
  localparam int EVT_W = 2;

  // Printed offsets are indices; byte address is four times the index
  localparam logic [5:0] IDX_CHECK_CARD = 6'h26;
  localparam logic [5:0] IDX_REF_STORE  = 6'h34;
  localparam logic [5:0] IDX_FIELD_ON   = 6'h36;
  localparam logic [5:0] IDX_THRESH     = 6'h37;
  localparam logic [5:0] IDX_SELECT     = 6'h38;
  localparam logic [5:0] IDX_LEAD       = 6'h39;
  localparam logic [5:0] IDX_TRAIL      = 6'h3a;
  localparam logic [5:0] IDX_GAIN_CFG   = 6'h3b;
  localparam logic [5:0] IDX_CTRL       = 6'h3c;
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h3d;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h3e;

  localparam int SEL_SRC_LSB   = 0;
  localparam int SEL_FIRST_SUPPLY_WAKE_OUTPUT_RF   = 2;
  localparam int SEL_SECOND_SUPPLY_WAKE_OUTPUT_DET  = 3;
  localparam int SEL_FIRST_SUPPLY_WAKE_OUTPUT_WAKE = 4;
  localparam logic [1:0] SRC_STORED   = 2'h0;
  localparam logic [1:0] SRC_MEASURE  = 2'h1;
  localparam logic [1:0] SRC_GAIN_CFG = 2'h2;
  localparam int CTRL_NEW_FW = 0;
  localparam int CTRL_LOOP   = 1;
  localparam int EVT_DETECT  = 0;
  localparam int EVT_DONE    = 1;
  localparam int CHK_BUSY    = 0;
  localparam int CHK_HIT     = 1;

  localparam logic [7:0]       BYTE_RST = 8'h00;
  localparam logic [REF_W-1:0] REF_RST  = 14'h0000;
  localparam logic [1:0]       CTRL_RST = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_STANDBY = 3'h1,
    ST_LEAD    = 3'h3,
    ST_FIELD   = 3'h2,
    ST_COMPARE = 3'h6,
    ST_TRAIL   = 3'h7
  } ldg_state_e;

  function automatic logic [DLY_W-1:0] delay_cycles(
    input logic [7:0] count,
    input logic       long_unit
  );
    logic [DLY_W-1:0] unit;
    unit = long_unit ? DLY_W'(FIELD_UNIT_CYC) : DLY_W'(LEAD_UNIT_CYC);
    return DLY_W'({9'h000, count} * unit);
  endfunction
endpackage
`default_nettype wire

// ---- shared/ldg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ldg_delay_if;
  logic       start;
  logic [7:0] count;
  logic       long_unit;
  logic       done;
  modport owner (output start, output count, output long_unit, input done);
  modport timer (input start, input count, input long_unit, output done);
endinterface

interface ldg_event_if;
  logic [1:0] evt;
  logic       stat_rd;
  logic [1:0] mask;
  logic [1:0] status;
  modport owner (output evt, output stat_rd, output mask, input status);
  modport keeper (input evt, input stat_rd, input mask, output status);
endinterface
`default_nettype wire

// ---- core/ldg_delay.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldg_delay #(
  parameter int DLY_W = ldg_pkg::DLY_W
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  ldg_delay_if.timer dly
);
  if (2 ** DLY_W <= 255 * ldg_pkg::FIELD_UNIT_CYC)
    $error("DLY_W too narrow for the longest delay");

  logic [DLY_W-1:0] remaining;
  logic             busy;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      remaining <= '0;
      busy      <= 1'b0;
      dly.done  <= 1'b0;
    end
    else if (clk_en)
    begin
      dly.done <= 1'b0;
      if (dly.start)
      begin
        remaining <= DLY_W'(ldg_pkg::delay_cycles(dly.count, dly.long_unit));
        busy      <= 1'b1;
      end
      else if (busy)
      begin
        if (remaining == '0)
        begin
          busy     <= 1'b0;
          dly.done <= 1'b1;
        end
        else
          remaining <= remaining - DLY_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/ldg_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldg_irq (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  ldg_event_if.keeper ev,
  output logic      irq
);
  logic [ldg_pkg::EVT_W-1:0] next_status;

  // New events win over the read that clears
  always_comb
  begin
    next_status = (ev.stat_rd ? '0 : ev.status) | ev.evt;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ev.status <= '0;
      irq       <= 1'b0;
    end
    else if (clk_en)
    begin
      ev.status <= next_status;
      irq       <= |(next_status & ev.mask);
    end
  end
endmodule
`default_nettype wire

// ---- verif/ldg_agc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldg_agc_model (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      rf_field_on,
  input  wire logic                      tick_en,
  input  wire logic [ldg_pkg::AGC_W-1:0] level,
  output logic      [ldg_pkg::AGC_W-1:0] agc_value,
  output logic                           wake_tick
);
  logic [2:0] hold;
  logic [5:0] cnt;

  // Gain loop value stays readable briefly after field off, then is junk
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      agc_value <= '0;
      hold <= 3'h0;
    end
    else if (rf_field_on)
    begin
      agc_value <= level;
      hold <= 3'h4;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    else
      agc_value <= ~agc_value;

  // Wake-up counter stand-in: one pulse every 64 cycles
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      cnt <= 6'h00;
    else if (tick_en)
      cnt <= cnt + 6'h01;
  assign wake_tick = tick_en && (cnt == 6'h3f);
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] ctrl;
    logic [7:0] sel;
    logic [7:0] lead;
    logic [7:0] trail;
    logic [9:0] lvl;
    logic [1:0] mask;
    logic       gpo;
    logic       hit;
  } ldg_row_s;
  localparam ldg_row_s ROWS [6] = '{
    '{2'h0, 8'h04, 8'h02, 8'h01, 10'h010, 2'h1, 1'b1, 1'b1},
    '{2'h0, 8'h00, 8'h01, 8'h01, 10'h1f8, 2'h1, 1'b0, 1'b0},
    '{2'h1, 8'h0a, 8'h01, 8'h01, 10'h010, 2'h0, 1'b0, 1'b1},
    '{2'h1, 8'h13, 8'h01, 8'h01, 10'h010, 2'h1, 1'b0, 1'b0},
    '{2'h1, 8'h05, 8'h00, 8'h02, 10'h200, 2'h1, 1'b1, 1'b0},
    '{2'h1, 8'h05, 8'h00, 8'h00, 10'h010, 2'h1, 1'b1, 1'b1}
  };
  localparam int S_FIELD = 0;
  localparam int S_WAKE1 = 1;
  localparam int S_IRQ   = 2;
  localparam logic [7:0] RADDR [11] = '{8'h98, 8'hd0, 8'hd8, 8'hdc,
    8'he0, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8};

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tick_en = 1'b0;
  logic        clk_en = 1'b1;
  logic        w1clr = 1'b0;
  logic [9:0]  lvl = 10'h000;
  logic [31:0] reg_rdata;
  logic [9:0]  agc_value;
  logic        wake_tick;
  logic        rf_field_on;
  logic        supply_wake1;
  logic        supply_wake2;
  logic        irq;
  logic        w1seen = 1'b0;
  int          num_errors = 0;
  int          checked = 0;

  always #10 mclk = ~mclk;

  always @(posedge mclk)
    if (w1clr)
      w1seen <= 1'b0;
    else if (supply_wake1 === 1'b1)
      w1seen <= 1'b1;

  ldg_low_power_card_detect ldg_low_power_card_detect_i (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wake_tick(wake_tick), .agc_value(agc_value),
    .rf_field_on(rf_field_on), .supply_wake1(supply_wake1),
    .supply_wake2(supply_wake2), .irq(irq));

  ldg_agc_model ldg_agc_model_i (
    .mclk(mclk), .reset(reset), .rf_field_on(rf_field_on),
    .tick_en(tick_en), .level(lvl), .agc_value(agc_value),
    .wake_tick(wake_tick));

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask

  function automatic logic sig(input int w);
    logic [2:0] all;
    all = {irq, supply_wake1, rf_field_on};
    return all[w];
  endfunction

  task automatic wt(input int w, input logic v, input int lim,
                    output int n);
    n = 0;
    while (sig(w) !== v && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (sig(w) !== v)
    begin
      num_errors++;
      $display("CHECK FAILED wait exp %b", v);
      summarize();
    end
  endtask

  initial
  begin
    ldg_row_s    r;
    logic [31:0] q;
    int          n;
    int          e;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    wr(8'hd0, 32'h200);
    wr(8'hd8, 32'h1);
    wr(8'hdc, 32'h10);
    wr(8'hec, 32'h200);
    wr(8'hfc, 32'hff);
    rd(8'hfc, q);
    chk("unmapped", 32'h0, q);
    rd(8'hdc, q);
    chk("thresh reg", 32'h10, q);
    rd(8'hec, q);
    chk("gain reg", 32'h200, q);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      lvl <= r.lvl;
      wr(8'hf0, {30'h0, r.ctrl});
      wr(8'hf8, {30'h0, r.mask});
      wr(8'he4, {24'h0, r.lead});
      wr(8'he8, {24'h0, r.trail});
      // Unchanged select keeps a measured reference armed
      if (i == 0 || r.sel !== ROWS[i-1].sel)
        wr(8'he0, {24'h0, r.sel});
      rd(8'he4, q);
      chk("lead reg", {24'h0, r.lead}, q);
      w1clr <= 1'b1;
      @(posedge mclk);
      w1clr <= 1'b0;
      wr(8'h98, 32'h1);
      #1;
      wt(S_FIELD, 1'b1, 2000, n);
      chk("wake1 at field", {31'h0, r.gpo}, {31'h0, supply_wake1});
      e = r.gpo ? r.lead * ldg_pkg::LEAD_UNIT_CYC + 2 : 0;
      chk("lead", 32'h1, 32'(n >= e && n <= e + 1));
      wt(S_FIELD, 1'b0, 2000, n);
      chk("field", 32'(ldg_pkg::FIELD_UNIT_CYC + 2), 32'(n));
      if (r.gpo)
      begin
        wt(S_WAKE1, 1'b0, 2000, n);
        e = r.trail * ldg_pkg::LEAD_UNIT_CYC + 2;
        chk("trail", 32'h1, 32'(n >= e && n <= e + 1));
      end
      repeat (6) @(posedge mclk);
      #1;
      chk("wake1 used", {31'h0, r.gpo}, {31'h0, w1seen});
      chk("wake2", {31'h0, r.hit & r.sel[3]}, {31'h0, supply_wake2});
      chk("irq", {31'h0, r.hit & r.mask[0]}, {31'h0, irq});
      rd(8'h98, q);
      chk("result", {30'h0, r.hit, 1'b0}, q);
      rd(8'hf4, q);
      chk("status", {30'h0, 1'b1, r.hit}, q);
      @(posedge mclk);
      #1;
      chk("cleared", 32'h0, {30'h0, irq, supply_wake2});
    end
    // Standby loop entered through wake ticks
    wr(8'he0, 32'h10);
    lvl <= 10'h1f8;
    wr(8'hf0, 32'h3);
    tick_en <= 1'b1;
    wt(S_FIELD, 1'b1, 600, n);
    chk("wake1 on wake", 32'h1, {31'h0, supply_wake1});
    // First pass misses, so a second field-on proves the standby return
    wt(S_FIELD, 1'b0, 600, n);
    lvl <= 10'h010;
    wt(S_FIELD, 1'b1, 600, n);
    chk("back to standby", 32'h0, {31'h0, irq});
    wt(S_IRQ, 1'b1, 3000, n);
    repeat (150) @(posedge mclk);
    #1;
    chk("loop stopped", 32'h0, {31'h0, rf_field_on});
    tick_en <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("reset outs", 32'h0,
        {28'h0, rf_field_on, supply_wake1, supply_wake2, irq});
    // Strobe with the clock enable low must leave the lead byte at zero
    clk_en <= 1'b0;
    wr(8'he4, 32'h55);
    clk_en <= 1'b1;
    foreach (RADDR[k])
    begin
      rd(RADDR[k], q);
      chk("reset reg", 32'h0, q);
    end
    wr(8'h98, 32'h1);
    rd(8'h98, q);
    chk("busy", 32'h1, q);
    summarize();
  end
endmodule
`default_nettype wire
